// *** rtl/tcdd_map.vh ***
// constants for the transmit context descriptor decoder
`ifndef TCDD_MAP_VH
`define TCDD_MAP_VH
// ------------------------------------------------------------
// register word offsets (avalon word addresses)
// ------------------------------------------------------------
`define TCDD_OFS_CTRL      4'h0
`define TCDD_OFS_DELAY     4'h1
`define TCDD_OFS_STATUS    4'h2
`define TCDD_OFS_IPSUM     4'h3
`define TCDD_OFS_L4SUM     4'h4
`define TCDD_OFS_SEG       4'h5
`define TCDD_OFS_PAYLOAD_TOTAL_LENGTH    4'h6
`define TCDD_OFS_WBDESC    4'h7
// ------------------------------------------------------------
// descriptor field positions (second qword lower half, bits 20 to 31)
// ------------------------------------------------------------
`define TCDD_DESCRIPTOR_TYPE_FIELD_LSB      20
`define TCDD_DESCRIPTOR_TYPE_FIELD_MSB      23
`define TCDD_CMD_LSB       24
`define TCDD_DESCRIPTOR_TYPE_FIELD_CTX      4'h0
`define TCDD_BIT_IDE       7
`define TCDD_BIT_SNAP      6
`define TCDD_BIT_DESCRIPTOR_EXTENSION_FLAG      5
`define TCDD_BIT_RS        3
`define TCDD_BIT_TSE       2
`define TCDD_BIT_IP        1
`define TCDD_BIT_TCP       0
`define TCDD_STA_DD        4'h1
// ------------------------------------------------------------
// limits and reset values
// ------------------------------------------------------------
`define TCDD_OFS_LIMIT     9'h100
`define TCDD_MSS_MIN       16'h0010
`define TCDD_RST_DELAY     16'h0000
`define TCDD_RST_CTRL      2'h0
`endif

// *** rtl/tcdd_decoder.v ***
// transmit context descriptor decoder with delayed-interrupt timer
// Overview of operation
// - extension flag 1 and type zero means context descriptor, not data descriptor.
// - context carries no buffer; its fields load as one group into a context.
// - ip sum start is byte offset from first byte, within first 256 bytes.
// - ip insert offset within 256 bytes; beyond packet length no insertion.
// - ip sum end is 16 bits; zero means sum to end of packet.
// - l4 start, offset and end follow the same meaning for layer four.
// - frames carry at most max segment size plus header; ignored without segmentation.
// - first header-length bytes become a prototype header per frame in segmentation.
// - exactly payload total length bytes fetched after header; marks last frame.
// - command bit layout; only delay, extension, report honoured without segmentation.
// - report plus delay write-back loads countdown; interrupt at zero if enabled.
// - countdown reloads on every report-plus-delay descriptor; report without delay fires at once.
// - status write-back never waits for the delayed interrupt.
// - done flag at status bit 0 written only when report status set.
// - null descriptors move nothing but still get done write-back on report.
// - segmentation bit picks which context loads, at once, even mid-packet.
// - ip bit picks ipv4 or ipv6; tcp bit picks tcp or udp.
// - snap bit in segmentation context marks snap header update per frame.
`timescale 1ns/100ps
`default_nettype none
`include "tcdd_map.vh"
module tcdd_decoder (
  input  wire        clk,
  input  wire        rst_n,
  // avalon-mm slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // descriptor fetch stream
  input  wire        desc_valid,
  input  wire [63:0] desc_lo,
  input  wire [63:0] desc_hi,
  output reg         desc_ready,
  // write-back stream
  output reg         wb_valid,
  output reg  [3:0]  wb_status,
  input  wire        wb_ready,
  // tick of the delay unit (1.024 us typical)
  input  wire        delay_tick,
  // context outputs toward the segmentation datapath, and the transmit interrupt
  output reg         seg_enable_o,
  output reg  [7:0]  ip_sum_start,
  output reg  [7:0]  ip_sum_insert_offset,
  output reg  [15:0] ip_sum_end,
  output reg  [7:0]  l4_sum_start,
  output reg  [7:0]  l4_sum_insert_offset,
  output reg  [15:0] l4_sum_end,
  output reg  [15:0] max_segment_size,
  output reg  [7:0]  header_length_field,
  output reg  [19:0] payload_total_length,
  output reg         ctx_ipv4,
  output reg         ctx_tcp,
  output reg         ctx_snap,
  output reg         ctx_load_pulse,
  output reg         tx_irq
);
  // ------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_WB   = 2'd1;
  localparam [1:0] ST_ACK  = 2'd2;

  reg [1:0]  state_r;
  reg [1:0]  ctrl_r;          // bit0 writeback irq enable, bit1 stored only, no effect
  reg [15:0] delay_value_field_r;
  reg [15:0] countdown_r;
  reg        counting_r;
  reg        cause_r;
  reg        pend_ide_r;
  reg        pend_rs_r;
  reg        ctx_err_r;
  reg [31:0] ctx_count_r;

  wire [7:0] context_command_byte = desc_hi[`TCDD_CMD_LSB+7:`TCDD_CMD_LSB];
  wire [3:0] descriptor_type_field = desc_hi[`TCDD_DESCRIPTOR_TYPE_FIELD_MSB:`TCDD_DESCRIPTOR_TYPE_FIELD_LSB];
  wire       descriptor_extension_flag = context_command_byte[`TCDD_BIT_DESCRIPTOR_EXTENSION_FLAG];
  wire       is_ctx = descriptor_extension_flag &&
                      (descriptor_type_field == `TCDD_DESCRIPTOR_TYPE_FIELD_CTX);
  wire       report_status_flag = context_command_byte[`TCDD_BIT_RS];
  wire       irq_delay_enable   = context_command_byte[`TCDD_BIT_IDE];
  wire       segmentation_enable = context_command_byte[`TCDD_BIT_TSE];
  wire       take = desc_valid && desc_ready;
  // driver limits are not enforced, only flagged, so software can see a bad context
  wire       seg_bad = segmentation_enable &&
               ((desc_hi[63:48] <= `TCDD_MSS_MIN));

  // ------------------------------------------------------------
  // descriptor intake and context load
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r              <= ST_IDLE;
      desc_ready           <= 1'b0;
      wb_valid             <= 1'b0;
      wb_status            <= 4'h0;
      seg_enable_o         <= 1'b0;
      ip_sum_start         <= 8'h00;
      ip_sum_insert_offset <= 8'h00;
      ip_sum_end           <= 16'h0000;
      l4_sum_start         <= 8'h00;
      l4_sum_insert_offset <= 8'h00;
      l4_sum_end           <= 16'h0000;
      max_segment_size     <= 16'h0000;
      header_length_field  <= 8'h00;
      payload_total_length <= 20'h00000;
      ctx_ipv4             <= 1'b0;
      ctx_tcp              <= 1'b0;
      ctx_snap             <= 1'b0;
      ctx_load_pulse       <= 1'b0;
      pend_ide_r           <= 1'b0;
      pend_rs_r            <= 1'b0;
      ctx_err_r            <= 1'b0;
      ctx_count_r          <= 32'h00000000;
    end else begin
      ctx_load_pulse <= 1'b0;
      pend_rs_r      <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          desc_ready <= 1'b1;
          if (take) begin
            desc_ready <= 1'b0;
            if (is_ctx) begin
              // sums and mode load in one edge, segment fields too when segmenting, even mid-packet
              ctx_load_pulse       <= 1'b1;
              ctx_count_r          <= ctx_count_r + 32'h00000001;
              ip_sum_start         <= desc_lo[7:0];
              ip_sum_insert_offset <= desc_lo[15:8];
              ip_sum_end           <= desc_lo[31:16];
              l4_sum_start         <= desc_lo[39:32];
              l4_sum_insert_offset <= desc_lo[47:40];
              l4_sum_end           <= desc_lo[63:48];
              seg_enable_o         <= segmentation_enable;
              if (segmentation_enable) begin
                // segment fields only matter in segmentation mode
                max_segment_size     <= desc_hi[63:48];
                header_length_field  <= desc_hi[47:40];
                payload_total_length <= desc_hi[19:0];
                ctx_ipv4             <= context_command_byte[`TCDD_BIT_IP];
                ctx_tcp              <= context_command_byte[`TCDD_BIT_TCP];
                ctx_snap             <= context_command_byte[`TCDD_BIT_SNAP];
              end else begin
                ctx_ipv4 <= 1'b0;
                ctx_tcp  <= 1'b0;
                ctx_snap <= 1'b0;
              end
              ctx_err_r <= seg_bad;
            end
            if (report_status_flag) begin
              // done flag goes out at once, never held for the timer
              wb_valid   <= 1'b1;
              wb_status  <= `TCDD_STA_DD;
              pend_ide_r <= irq_delay_enable;
              state_r    <= ST_WB;
            end else begin
              state_r <= ST_ACK;
            end
          end
        end
        ST_WB: begin
          if (wb_ready) begin
            wb_valid  <= 1'b0;
            wb_status <= 4'h0;
            pend_rs_r <= 1'b1;
            state_r   <= ST_ACK;
          end
        end
        ST_ACK: begin
          desc_ready <= 1'b1;
          state_r    <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // interrupt delay countdown
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      countdown_r <= 16'h0000;
      counting_r  <= 1'b0;
      cause_r     <= 1'b0;
      tx_irq      <= 1'b0;
    end else begin
      cause_r <= 1'b0;
      if (pend_rs_r && pend_ide_r) begin
        // reload even while running
        countdown_r <= delay_value_field_r;
        counting_r  <= 1'b1;
        if (delay_value_field_r == 16'h0000) begin
          counting_r <= 1'b0;
          cause_r    <= 1'b1;
        end
      end else if (pend_rs_r) begin
        countdown_r <= 16'h0000;
        counting_r  <= 1'b0;
        cause_r     <= 1'b1;
      end else if (counting_r && delay_tick) begin
        if (countdown_r <= 16'h0001) begin
          countdown_r <= 16'h0000;
          counting_r  <= 1'b0;
          cause_r     <= 1'b1;
        end else begin
          countdown_r <= countdown_r - 16'h0001;
        end
      end
      tx_irq <= cause_r && ctrl_r[0];
    end
  end

  // ------------------------------------------------------------
  // avalon-mm slave, one wait cycle then answer
  // ------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest     <= 1'b1;
      avs_readdata        <= 32'h00000000;
      ctrl_r              <= `TCDD_RST_CTRL;
      delay_value_field_r <= `TCDD_RST_DELAY;
    end else begin
      avs_waitrequest <= 1'b1;
      if ((avs_read || avs_write) && avs_waitrequest) begin
        avs_waitrequest <= 1'b0;
      end
      if ((avs_read || avs_write) && !avs_waitrequest) begin
        avs_waitrequest <= 1'b1;
      end
      // a write lands only at the edge that completes the transfer
      if (avs_write && !avs_waitrequest) begin
        case (avs_address)
          `TCDD_OFS_CTRL: begin
            if (avs_byteenable[0]) ctrl_r <= avs_writedata[1:0];
          end
          `TCDD_OFS_DELAY: begin
            if (avs_byteenable[0]) delay_value_field_r[7:0]  <= avs_writedata[7:0];
            if (avs_byteenable[1]) delay_value_field_r[15:8] <= avs_writedata[15:8];
          end
          default: begin
          end
        endcase
      end
      if (avs_read && avs_waitrequest) begin
        case (avs_address)
          `TCDD_OFS_CTRL:   avs_readdata <= {30'h0, ctrl_r};
          `TCDD_OFS_DELAY:  avs_readdata <= {16'h0000, delay_value_field_r};
          `TCDD_OFS_STATUS: avs_readdata <= {12'h000, countdown_r, 1'b0, ctx_err_r,
                                             counting_r, seg_enable_o};
          `TCDD_OFS_IPSUM:  avs_readdata <= {ip_sum_end, ip_sum_insert_offset, ip_sum_start};
          `TCDD_OFS_L4SUM:  avs_readdata <= {l4_sum_end, l4_sum_insert_offset, l4_sum_start};
          `TCDD_OFS_SEG:    avs_readdata <= {5'h00, ctx_snap, ctx_tcp, ctx_ipv4,
                                             header_length_field, max_segment_size};
          `TCDD_OFS_PAYLOAD_TOTAL_LENGTH: avs_readdata <= {12'h000, payload_total_length};
          `TCDD_OFS_WBDESC: avs_readdata <= ctx_count_r;
          default:          avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // tcdd_decoder
`default_nettype wire

// *** bench/tcdd_checker.sv ***
// port checker for the context descriptor decoder
`timescale 1ns/100ps
`default_nettype none
module tcdd_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        desc_valid,
  input wire logic        desc_ready,
  input wire logic [63:0] desc_lo,
  input wire logic [63:0] desc_hi,
  input wire logic        wb_valid,
  input wire logic [3:0]  wb_status,
  input wire logic        wb_ready,
  input wire logic        seg_enable_o,
  input wire logic [7:0]  ip_sum_start,
  input wire logic [15:0] max_segment_size,
  input wire logic        ctx_ipv4,
  input wire logic        ctx_tcp,
  input wire logic        ctx_snap,
  input wire logic        ctx_load_pulse
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire take = desc_valid && desc_ready;
  wire ctx  = take && desc_hi[29] && desc_hi[23:20] == 4'h0;
  property p_wb_rise; take && desc_hi[27] |=> wb_valid; endproperty
  a_wb_rise: assert property (p_wb_rise) else $error("write-back late");
  property p_wb_none; take && !desc_hi[27] |=> !wb_valid; endproperty
  a_wb_none: assert property (p_wb_none) else $error("write-back without report");
  property p_wb_hold; wb_valid && !wb_ready |=> wb_valid && $stable(wb_status); endproperty
  a_wb_hold: assert property (p_wb_hold) else $error("write-back dropped");
  property p_wb_sta; wb_valid |-> wb_status == 4'h1; endproperty
  a_wb_sta: assert property (p_wb_sta) else $error("bad status nibble");
  property p_load; ctx |-> ##[1:2] ctx_load_pulse; endproperty
  a_load: assert property (p_load) else $error("context not loaded");
  property p_noload; take && !ctx |=> !ctx_load_pulse [*2]; endproperty
  a_noload: assert property (p_noload) else $error("data descriptor loaded");
  property p_seg;
    ctx |=> seg_enable_o == $past(desc_hi[26]) && ip_sum_start == $past(desc_lo[7:0]);
  endproperty
  a_seg: assert property (p_seg) else $error("mode or start wrong");
  property p_mss;
    ctx && desc_hi[26] |=> max_segment_size == $past(desc_hi[63:48])
      && ctx_ipv4 == $past(desc_hi[25]);
  endproperty
  a_mss: assert property (p_mss) else $error("segment fields wrong");
  property p_flags; ctx && !desc_hi[26] |=> !(ctx_ipv4 || ctx_tcp || ctx_snap); endproperty
  a_flags: assert property (p_flags) else $error("flags honoured without segmentation");
  c_seg: cover property (ctx && desc_hi[26]);
  c_stall: cover property (wb_valid && !wb_ready);
  c_data: cover property (take && !ctx);
endmodule // tcdd_checker
bind tcdd_decoder tcdd_checker u_chk (.clk, .rst_n, .desc_valid, .desc_ready, .desc_lo, .desc_hi,
  .wb_valid, .wb_status, .wb_ready, .seg_enable_o, .ip_sum_start, .max_segment_size, .ctx_ipv4,
  .ctx_tcp, .ctx_snap, .ctx_load_pulse);
`default_nettype wire

// *** bench/tcdd_host.sv ***
// host driver model: presents descriptors and accepts status write-backs
`timescale 1ns/100ps
`default_nettype none
module tcdd_host (
  input wire logic        clk,
  input wire logic        desc_ready,
  input wire logic        wb_valid,
  input wire logic [3:0]  wb_status,
  output var logic        desc_valid = 1'b0,
  output var logic [63:0] desc_lo = 64'h0,
  output var logic [63:0] desc_hi = 64'h0,
  output var logic        wb_ready = 1'b0
);
  int         wb_cnt = 0;
  int         stall = 0;
  int         st = 0;
  logic [3:0] wb_last = 4'h0;
  // a descriptor stands whole until taken; lines then carry junk, never the old value
  task send(input logic [63:0] lo, input logic [63:0] hi, output bit ok);
    int n;
    n = 0;
    @(posedge clk);
    desc_valid <= 1'b1;
    desc_lo <= lo;
    desc_hi <= hi;
    do begin
      @(posedge clk);
      n++;
    end while (desc_ready !== 1'b1 && n < 100);
    ok = n < 100;
    desc_valid <= 1'b0;
    desc_lo <= ~lo;
    desc_hi <= ~hi;
  endtask
  // slow memory: write-back accepted after a programmable stall
  always @(posedge clk) begin
    if (wb_valid === 1'b1 && !wb_ready && st >= stall) begin
      wb_ready <= 1'b1;
      wb_cnt <= wb_cnt + 1;
      wb_last <= wb_status;
      st <= 0;
    end else begin
      wb_ready <= 1'b0;
      st <= (wb_valid === 1'b1 && !wb_ready) ? st + 1 : 0;
    end
  end
endmodule // tcdd_host
`default_nettype wire

// *** bench/tcdd_tb.sv ***
// self-checking bench for the context descriptor decoder
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, delay_tick = 0;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hF, wb_status, m_fl = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q, r = 32'd99193;
  logic        avs_waitrequest, desc_valid, desc_ready, wb_valid, wb_ready, seg_enable_o;
  logic        ctx_ipv4, ctx_tcp, ctx_snap, ctx_load_pulse, tx_irq;
  logic [63:0] desc_lo, desc_hi, lo, hi, m_lo = 64'h0;
  logic [43:0] m_seg = 44'h0;
  logic [7:0]  ip_sum_start, ip_sum_insert_offset, l4_sum_start, l4_sum_insert_offset;
  logic [7:0]  header_length_field, cmd;
  logic [15:0] ip_sum_end, l4_sum_end, max_segment_size;
  logic [19:0] payload_total_length;
  int          bad_count = 0, samples_checked = 0, irq_cnt = 0, n_ctx = 0;
  int          exp_wb[$];
  always #12.5 clk = ~clk;
  always @(posedge clk) if (tx_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  tcdd_decoder dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .desc_valid, .desc_lo, .desc_hi, .desc_ready, .wb_valid, .wb_status,
    .wb_ready, .delay_tick, .seg_enable_o, .ip_sum_start, .ip_sum_insert_offset,
    .ip_sum_end, .l4_sum_start, .l4_sum_insert_offset, .l4_sum_end,
    .max_segment_size, .header_length_field, .payload_total_length,
    .ctx_ipv4, .ctx_tcp, .ctx_snap, .ctx_load_pulse, .tx_irq);
  tcdd_host u_host (.clk, .desc_ready, .wb_valid, .wb_status, .desc_valid,
    .desc_lo, .desc_hi, .wb_ready);
  function logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cyc(input int n); repeat (n) @(posedge clk); endtask
  task tick(input int n);
    repeat (n) begin
      @(posedge clk);
      delay_tick <= 1'b1;
      @(posedge clk);
      delay_tick <= 1'b0;
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin bad_count++; close_out; end
  endtask
  // send one descriptor, update the model, compare the loaded context and write-backs
  task put(input logic [63:0] l, input logic [63:0] h);
    bit ok;
    int n;
    n = 0;
    u_host.send(l, h, ok);
    if (h[27]) exp_wb.push_back(1);
    if (h[29] && h[23:20] == 4'h0) begin
      n_ctx++;
      m_lo = l;
      m_fl = h[26] ? {1'b1, h[25], h[24], h[30]} : 4'h0;
      if (h[26]) m_seg = {h[63:40], h[19:0]};
    end
    @(posedge clk);
    #1;
    chk("sums", m_lo, {l4_sum_end, l4_sum_insert_offset, l4_sum_start,
        ip_sum_end, ip_sum_insert_offset, ip_sum_start});
    chk("segment", m_seg,
        {max_segment_size, header_length_field, payload_total_length});
    chk("flags", m_fl, {seg_enable_o, ctx_ipv4, ctx_tcp, ctx_snap});
    while (desc_ready !== 1'b1 && n < 50) begin @(posedge clk); n++; end
    if (!ok || n >= 50) begin bad_count++; close_out; end
    chk("wb count", exp_wb.size(), u_host.wb_cnt);
    chk("wb status", (exp_wb.size() > 0) ? 1 : 0, u_host.wb_last);
  endtask
  initial begin
    cyc(16);
    rst_n <= 1'b1;
    bus(0, 4'h0, 0);
    chk("ctrl reset", 0, q);
    bus(0, 4'h1, 0);
    chk("delay reset", 0, q);
    bus(1, 4'h1, 32'h3);
    bus(0, 4'h1, 0);
    chk("delay", 3, q);
    bus(1, 4'hC, 32'h5A);
    bus(0, 4'hC, 0);
    chk("unmapped", 0, q);
    $display("register test ended");
    for (int i = 0; i < 16; i++) begin
      r = lfsr(r);
      lo[31:0] = r;
      r = lfsr(r);
      lo[63:32] = r;
      r = lfsr(r);
      cmd = {r[7:6], 1'b1, r[4], i[0], i[1], r[1:0]};
      u_host.stall = r[9:8];
      // r[10] plays vlan mode enable: clear keeps the tag bytes in the buffer
      lo[7:0] = r[10] ? 8'h0E : 8'h12;
      lo[39:32] = lo[7:0] + 8'h14;
      if (!cmd[1]) lo[31:16] = 16'h0000;
      hi = {16'h0011 + r[31:17], r[23:16], 8'h00, cmd, 4'h0, r[19:0]};
      put(lo, hi);
    end
    put(~lo, {hi[63:32], 8'h20, 4'h1, hi[19:0]});
    put(lo, {hi[63:32], 8'h04, 4'h0, hi[19:0]});
    bus(0, 4'h3, 0);
    chk("ip sum reg", m_lo[31:0], q);
    bus(0, 4'h4, 0);
    chk("l4 sum reg", m_lo[63:32], q);
    bus(0, 4'h5, 0);
    chk("seg reg", {m_fl[0], m_fl[1], m_fl[2], m_seg[27:20], m_seg[43:28]}, q);
    bus(0, 4'h6, 0);
    chk("payload_total_length reg", m_seg[19:0], q);
    bus(0, 4'h7, 0);
    chk("ctx count", n_ctx, q);
    $display("context test ended");
    bus(1, 4'h0, 1);
    put(0, 64'hA800_0000);
    cyc(4);
    tick(2);
    cyc(3);
    chk("irq early", 0, irq_cnt);
    put(0, 64'hA800_0000);
    cyc(4);
    tick(2);
    cyc(3);
    chk("irq reload", 0, irq_cnt);
    tick(1);
    cyc(3);
    chk("irq delayed", 1, irq_cnt);
    put(0, 64'h2800_0000);
    cyc(4);
    chk("irq now", 2, irq_cnt);
    bus(1, 4'h0, 0);
    put(0, 64'h2800_0000);
    cyc(4);
    chk("irq masked", 2, irq_cnt);
    put(0, 64'h0010_0000_2C00_0000);
    bus(0, 4'h2, 0);
    chk("status", 32'h5, q);
    $display("interrupt test ended");
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    bus(0, 4'h7, 0);
    chk("count after reset", 0, q);
    chk("ctx after reset", 0, {seg_enable_o, ip_sum_start, max_segment_size});
    $display("reset test ended");
    close_out;
  end
  initial begin
    cyc(20000);
    bad_count++;
    close_out;
  end
endmodule // testbench
`default_nettype wire
